/* logic/bou_defines.svh */
// Encoding constants and timing counts for the bit-operation unit
`ifndef BOU_DEFINES_SVH
`define BOU_DEFINES_SVH
`define BOU_GROUP_HI         13
`define BOU_GROUP_LO         12
`define BOU_GROUP_BITOP      2'h1
`define BOU_OP_HI            11
`define BOU_OP_LO            10
`define BOU_OP_CLEAR         2'h0
`define BOU_OP_SET           2'h1
`define BOU_OP_SKIP_ZERO     2'h2
`define BOU_OP_SKIP_ONE      2'h3
`define BOU_BIT_HI           9
`define BOU_BIT_LO           7
`define BOU_ADDR_HI          6
`define BOU_ADDR_LO          0
`define BOU_NOP_WORD         14'h0000
`define BOU_SKIP_CYCLES      2
`endif

/* logic/bou_pkg.sv */
// Types shared by the bit-operation unit
package bou_pkg;
    typedef logic [13:0] bou_word_type;
    typedef logic [6:0]  bou_addr_type;
    typedef logic [7:0]  bou_data_type;
    typedef struct packed {
        logic         we;
        bou_addr_type addr;
        bou_data_type data;
    } bou_wr_type;
    typedef struct packed {
        logic         valid;
        logic         skip;
        logic         busy;
    } bou_stat_type;
    typedef enum logic [1:0] {
        BOU_ST_RUN   = 2'b01,
        BOU_ST_FLUSH = 2'b10
    } bou_state_type;
endpackage : bou_pkg

/* logic/bou_bit_alu.sv */
// Bit clear/set/test datapath on one register byte
`timescale 1ns/1ns
`include "bou_defines.svh"
module bou_bit_alu (
    input  wire logic [1:0] op,      // Bit operation selector
    input  wire logic [2:0] bit_sel, // Bit index
    input  wire logic [7:0] din,     // Register operand
    output logic      [7:0] dout,    // Modified byte
    output logic            bit_val  // Selected bit value
);
    logic [7:0] mask;
    always_comb begin
        mask    = 8'h01 << bit_sel;
        bit_val = |(din & mask);
        case (op)
            `BOU_OP_CLEAR: dout = din & ~mask;
            `BOU_OP_SET:   dout = din | mask;
            default:       dout = din;
        endcase
    end
endmodule : bou_bit_alu

/* logic/bou_unit.sv */
// Decode and execute unit for the four single-bit instructions
`timescale 1ns/1ns
`include "bou_defines.svh"
module bou_unit (
    input  wire logic                 clk,        // Instruction clock, 100 MHz
    input  wire logic                 rst_n,      // Synchronous reset, active low
    input  wire logic                 ce,         // Clock enable, freezes state when low
    input  wire logic                 instr_valid, // Instruction word present
    input  bou_pkg::bou_word_type     instr,      // Instruction word in execute
    input  bou_pkg::bou_data_type     rd_data,    // Register file data at addressed location
    output bou_pkg::bou_addr_type     rd_addr,    // Register file read address (registered)
    output bou_pkg::bou_wr_type       wr,         // Register file write port
    output bou_pkg::bou_stat_type     stat,       // Execution status
    output bou_pkg::bou_word_type     exec_word   // Word actually executed (no-op on flush)
);
    import bou_pkg::*;

    bou_state_type state_reg, state_next;
    bou_wr_type    wr_reg, wr_next;
    bou_stat_type  stat_reg, stat_next;
    bou_addr_type  rd_addr_reg, rd_addr_next;
    bou_word_type  exec_reg, exec_next;

    logic [1:0]   op;
    logic         is_bitop;
    bou_data_type alu_out;
    logic         bit_val;

    assign is_bitop = instr_valid && (instr[`BOU_GROUP_HI:`BOU_GROUP_LO] == `BOU_GROUP_BITOP);
    assign op       = instr[`BOU_OP_HI:`BOU_OP_LO];

    bou_bit_alu u_alu (
        .op      (op),
        .bit_sel (instr[`BOU_BIT_HI:`BOU_BIT_LO]),
        .din     (rd_data),
        .dout    (alu_out),
        .bit_val (bit_val)
    );

    always_comb begin
        state_next   = state_reg;
        wr_next      = '0;
        stat_next    = '0;
        rd_addr_next = instr[`BOU_ADDR_HI:`BOU_ADDR_LO];
        exec_next    = instr;
        case (state_reg)
            BOU_ST_RUN: begin
                if (is_bitop) begin
                    stat_next.valid = 1'b1;
                    case (op)
                        `BOU_OP_CLEAR, `BOU_OP_SET: begin
                            // Write-back of the one byte only; no flag update path exists
                            wr_next.we   = 1'b1;
                            wr_next.addr = instr[`BOU_ADDR_HI:`BOU_ADDR_LO];
                            wr_next.data = alu_out;
                        end
                        `BOU_OP_SKIP_ZERO: begin
                            if (!bit_val) begin
                                stat_next.skip = 1'b1;
                                stat_next.busy = 1'b1;
                                state_next     = BOU_ST_FLUSH;
                            end
                        end
                        default: begin
                            if (bit_val) begin
                                stat_next.skip = 1'b1;
                                stat_next.busy = 1'b1;
                                state_next     = BOU_ST_FLUSH;
                            end
                        end
                    endcase
                end
            end
            BOU_ST_FLUSH: begin
                // Prefetched word is dropped; second cycle is a no-op
                exec_next  = `BOU_NOP_WORD;
                state_next = BOU_ST_RUN;
            end
            default: state_next = BOU_ST_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg   <= BOU_ST_RUN;
            wr_reg      <= '0;
            stat_reg    <= '0;
            rd_addr_reg <= '0;
            exec_reg    <= `BOU_NOP_WORD;
        end else if (ce) begin
            state_reg   <= state_next;
            wr_reg      <= wr_next;
            stat_reg    <= stat_next;
            rd_addr_reg <= rd_addr_next;
            exec_reg    <= exec_next;
        end
    end

    assign wr        = wr_reg;
    assign stat      = stat_reg;
    assign rd_addr   = rd_addr_reg;
    assign exec_word = exec_reg;
endmodule : bou_unit

/* testbench/bou_unit_chk.sv */
// Port-level assertions for the bit-operation unit
`timescale 1ns/1ns
module bou_unit_chk import bou_pkg::*; (
    input wire logic   clk,         // Clock
    input wire logic   rst_n,       // Reset, active low
    input wire logic   ce,          // Clock enable
    input wire logic   instr_valid, // Word present
    input bou_word_type instr,      // Word in execute
    input bou_data_type rd_data,    // Register byte
    input bou_addr_type rd_addr,    // Read address
    input bou_wr_type   wr,         // Write port
    input bou_stat_type stat,       // Status
    input bou_word_type exec_word   // Executed word
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic tk;
    logic bv;
    // Flush slot after a skip takes nothing
    assign tk = ce && instr_valid && instr[13:12] == 2'h1 && !stat.skip;
    assign bv = rd_data[instr[9:7]];
    sequence s_nop_slot;
        stat.skip && stat.busy ##1 exec_word == 14'h0000 && !wr.we;
    endsequence
    a_clear_write: assert property (tk && instr[11:10] == 2'h0 |=> wr.we && wr.addr == $past(instr[6:0])
        && wr.data == ($past(rd_data) & ~(8'h01 << $past(instr[9:7])))) else $error("clear write wrong");
    a_set_write: assert property (tk && instr[11:10] == 2'h1 |=> wr.we
        && wr.data == ($past(rd_data) | (8'h01 << $past(instr[9:7])))) else $error("set write wrong");
    a_skip_zero: assert property (tk && instr[11:10] == 2'h2 |=> stat.skip == !$past(bv))
        else $error("skip on zero wrong");
    a_skip_one: assert property (tk && instr[11:10] == 2'h3 |=> stat.skip == $past(bv))
        else $error("skip on one wrong");
    a_flush_nop: assert property (tk && instr[11] && instr[10] == bv |=> s_nop_slot)
        else $error("flush slot wrong");
    a_other_bits: assert property (wr.we |-> $onehot0(wr.data ^ $past(rd_data)))
        else $error("untargeted bit changed");
    a_addr_follow: assert property (rst_n && ce |=> rd_addr == $past(instr[6:0]))
        else $error("read address not registered");
    a_freeze_hold: assert property (rst_n && !ce |=> $stable(wr) && $stable(stat) && $stable(exec_word))
        else $error("state moved while frozen");
endmodule : bou_unit_chk
bind bou_unit bou_unit_chk i_bou_unit_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid),
    .instr(instr), .rd_data(rd_data), .rd_addr(rd_addr), .wr(wr), .stat(stat), .exec_word(exec_word));

/* testbench/test_bou_unit.sv */
// Self-checking bench for the bit-operation unit
`timescale 1ns/1ns
module test_bou_unit;
    import bou_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, instr_valid = 1'b0;
    bou_word_type instr = 14'h0000, exec_word;
    bou_data_type rd_data, mem [128];
    bou_addr_type rd_addr;
    bou_wr_type wr;
    bou_stat_type stat;
    int err_count = 0, checks_done = 0;
    assign rd_data = mem[instr[6:0]];
    bou_unit i_bou_unit (.clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid), .instr(instr),
        .rd_data(rd_data), .rd_addr(rd_addr), .wr(wr), .stat(stat), .exec_word(exec_word));
    task automatic send(input bou_word_type w);
        @(posedge clk);
        instr <= w;
        instr_valid <= 1'b1;
    endtask : send
    task automatic chk(input logic ok);
        checks_done++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: port mismatch", $time);
        end
    endtask : chk
    task automatic t_write;
        mem[7'h10] = 8'hc7;
        mem[7'h11] = 8'h0a;
        send(14'h1390);
        send(14'h1791);
        #1 chk(wr.we === 1'b1 && wr.addr === 7'h10 && wr.data === 8'h47);
        send(14'h0000);
        #1 chk(wr.we === 1'b1 && wr.addr === 7'h11 && wr.data === 8'h8a && rd_addr === 7'h11);
    endtask : t_write
    task automatic t_freeze;
        mem[7'h30] = 8'hff;
        @(posedge clk);
        ce <= 1'b0;
        instr <= {2'h1, 2'h0, 3'h0, 7'h30};
        repeat (2) @(posedge clk);
        #1 chk(wr.we === 1'b0 && stat === 3'h0);
        @(posedge clk);
        ce <= 1'b1;
        send(14'h0000);
        #1 chk(wr.we === 1'b1 && wr.addr === 7'h30 && wr.data === 8'hfe);
    endtask : t_freeze
    task automatic t_skip(input logic [1:0] op, input logic b, input logic exp);
        mem[7'h20] = b ? 8'h02 : 8'hfd;
        send({2'h1, op, 3'h1, 7'h20});
        // Word behind the test sets bit 6; it must vanish when skipped
        send(14'h1720);
        #1 chk(stat.valid === 1'b1 && stat.skip === exp && stat.busy === exp);
        send(14'h0000);
        #1 chk(exec_word === (exp ? 14'h0000 : 14'h1720) && wr.we === !exp);
    endtask : t_skip
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_write();
        t_skip(2'h2, 1'b0, 1'b1);
        t_skip(2'h2, 1'b1, 1'b0);
        t_skip(2'h3, 1'b1, 1'b1);
        t_skip(2'h3, 1'b0, 1'b0);
        t_freeze();
        wrap_up();
    end
endmodule : test_bou_unit
